//--- hdl/spca_top.sv
// Command decoder and control/status space of the serial programming access layer.
// Overview of operation
// RQ1: Opcode 1aa1aaaa writes next received byte to six-bit I/O address.
// RQ2: Opcode 1000aaaa loads addressed control/status byte into shift register for sending.
// RQ3: Opcode 1100aaaa writes next received byte to addressed control/status register.
// RQ4: Opcode 11100000 is followed by exactly eight key bytes, all collected.
// RQ5: Memory programming stays disabled after reset until the correct key arrives.
// RQ6: Programming is enabled only when the eight bytes equal 0x1289AB45CDD888FF.
// RQ7: Programmer polls status until the enable flag is set before programming.
// RQ8: Writing zero to the enable bit disables programming and clears the flag.
// RQ9: Control/status registers are reachable only by control/status load and store.
// RQ10: Address 0x0F reads a fixed read-only identification code.
// RQ11: Guard field 000..111 selects 128,64,32,16,8,4,2,0 extra idle bits.
// RQ12: Receive-to-transmit turnaround waits guard bits plus two idle bits.
// RQ13: Transmit-to-receive turnaround adds no guard idle bits.
// RQ14: Guard field resets to 000, giving 128 extra idle bits.
// RQ15: Programmer should lower the guard setting to the shortest reliable value.
// RQ16: Reserved control and status bits always read as zero.
// RQ17: Status bit 1 reads one while memory programming is enabled.
// RQ18: Messages start with a programmer instruction; loads answer, stores take operands.
// RQ19: A mismatching key leaves programming disabled with no other effect.
`timescale 1ns/10ps

module spca_top #(
    parameter logic [7:0] IDENT_CODE = 8'h5A  // Arbitrary neutral value.
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // Bytes received by the physical layer.
    input  wire spca_pkg::spca_byte_t rx_byte,
    // Load answer towards the physical layer shift register.
    output logic                   tx_load,
    output logic [7:0]             tx_data,
    output logic [7:0]             turn_idle_bits,
    // I/O space store.
    output spca_pkg::spca_io_wr_t  io_wr,
    // Memory controller access.
    output logic                   mem_prog_enabled
);

    typedef enum logic [3:0] {
        SPCA_ST_CMD   = 4'b0001,
        SPCA_ST_IO    = 4'b0010,
        SPCA_ST_CS    = 4'b0100,
        SPCA_ST_KEY   = 4'b1000
    } spca_state_t;

    spca_state_t  state_reg;
    spca_state_t  state_next;
    logic [5:0]   io_addr_reg;
    logic [3:0]   cs_addr_reg;
    logic [3:0]   key_cnt_reg;
    logic [63:0]  key_reg;
    logic [2:0]   guard_time_reg;
    logic         mem_en_reg;
    logic [7:0]   cs_read;
    logic [7:0]   rd;
    logic         is_io;
    logic         is_cs_ld;
    logic         is_cs_st;
    logic         is_key;
    logic         key_done;
    logic         cs_wr;
    logic [63:0]  key_full;

    assign rd       = rx_byte.data;
    assign is_io    = (rd & spca_pkg::SPCA_IO_STORE_MASK) == spca_pkg::SPCA_IO_STORE_VAL;
    assign is_cs_ld = (rd & spca_pkg::SPCA_NIB_MASK) == spca_pkg::SPCA_CS_LOAD_VAL;
    assign is_cs_st = (rd & spca_pkg::SPCA_NIB_MASK) == spca_pkg::SPCA_CS_STORE_VAL;
    assign is_key   = rd == spca_pkg::SPCA_KEY_CMD;
    assign key_full = {key_reg[55:0], rd};
    assign key_done = rx_byte.valid && (state_reg == SPCA_ST_KEY)
                      && (key_cnt_reg == spca_pkg::SPCA_KEY_LAST);
    assign cs_wr    = rx_byte.valid && (state_reg == SPCA_ST_CS);

    // Instruction sequencing; every message opens in the command state.
    always_comb begin
        state_next = state_reg;
        if (rx_byte.valid) begin
            unique case (state_reg)
                SPCA_ST_CMD: begin
                    if (is_key) begin
                        state_next = SPCA_ST_KEY; // see RQ4
                    end else if (is_cs_st) begin
                        state_next = SPCA_ST_CS; // see RQ3
                    end else if (is_io) begin
                        state_next = SPCA_ST_IO; // see RQ1
                    end else begin
                        state_next = SPCA_ST_CMD; // see RQ18
                    end
                end
                SPCA_ST_IO:  state_next = SPCA_ST_CMD;
                SPCA_ST_CS:  state_next = SPCA_ST_CMD;
                SPCA_ST_KEY: begin
                    if (key_done) begin
                        state_next = SPCA_ST_CMD;
                    end
                end
                default:     state_next = SPCA_ST_CMD;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= SPCA_ST_CMD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operand addresses captured from the instruction byte.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            io_addr_reg <= 6'h00;
            cs_addr_reg <= 4'h0;
        end else if (rx_byte.valid && state_reg == SPCA_ST_CMD) begin
            io_addr_reg <= {rd[6:5], rd[3:0]}; // see RQ1
            cs_addr_reg <= rd[3:0];
        end
    end

    // Key byte collection, first byte ends up most significant.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            key_cnt_reg <= 4'h0;
            key_reg     <= 64'h0;
        end else if (rx_byte.valid && state_reg == SPCA_ST_CMD && is_key) begin
            key_cnt_reg <= 4'h0;
        end else if (rx_byte.valid && state_reg == SPCA_ST_KEY) begin
            key_reg     <= key_full; // see RQ4
            key_cnt_reg <= key_cnt_reg + 4'h1;
        end
    end

    // Memory programming enable flag.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mem_en_reg <= 1'b0; // see RQ5
        end else if (key_done && key_full == spca_pkg::SPCA_ACT_KEY) begin
            mem_en_reg <= 1'b1; // see RQ6
        end else if (cs_wr && cs_addr_reg == spca_pkg::SPCA_ADDR_STATUS
                     && !rd[spca_pkg::SPCA_MEM_EN_BIT]) begin
            mem_en_reg <= 1'b0; // see RQ8
        end
        // A mismatching key falls through and changes nothing, see RQ19.
    end

    // Guard time field of the physical layer control register.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            guard_time_reg <= spca_pkg::SPCA_GUARD_RESET; // see RQ14
        end else if (cs_wr && cs_addr_reg == spca_pkg::SPCA_ADDR_PHY_CTRL) begin
            guard_time_reg <= rd[2:0]; // see RQ3
        end
    end

    // Control/status read mux, reached only through the load instruction.
    always_comb begin
        cs_read = 8'h00; // see RQ16
        unique case (rd[3:0])
            spca_pkg::SPCA_ADDR_STATUS: begin
                cs_read[spca_pkg::SPCA_MEM_EN_BIT] = mem_en_reg; // see RQ17
            end
            spca_pkg::SPCA_ADDR_PHY_CTRL: cs_read[2:0] = guard_time_reg;
            spca_pkg::SPCA_ADDR_IDENT:    cs_read = IDENT_CODE; // see RQ10
            default:                      cs_read = 8'h00;
        endcase
    end

    // Load answer and I/O store outputs, registered; see RQ9.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_load <= 1'b0;
            tx_data <= 8'h00;
            io_wr   <= '0;
        end else begin
            tx_load        <= rx_byte.valid && state_reg == SPCA_ST_CMD && is_cs_ld; // see RQ2
            io_wr.valid    <= rx_byte.valid && state_reg == SPCA_ST_IO; // see RQ1
            io_wr.addr     <= io_addr_reg;
            io_wr.data     <= rd;
            if (rx_byte.valid && state_reg == SPCA_ST_CMD && is_cs_ld) begin
                tx_data <= cs_read; // see RQ2
            end
        end
    end

    // Turnaround idle count: guard bits plus two; transmit to receive adds none, see RQ13.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            turn_idle_bits <= spca_pkg::SPCA_GUARD_MAX + spca_pkg::SPCA_BASE_IDLE;
        end else if (guard_time_reg == 3'h7) begin
            turn_idle_bits <= spca_pkg::SPCA_BASE_IDLE; // see RQ11
        end else begin
            turn_idle_bits <= (spca_pkg::SPCA_GUARD_MAX >> guard_time_reg)
                              + spca_pkg::SPCA_BASE_IDLE; // see RQ12
        end
    end

    assign mem_prog_enabled = mem_en_reg; // see RQ5

endmodule

//--- include/spca_pkg.sv
// Package with constants and types for the serial programming command access block.
package spca_pkg;

    // Opcode patterns and masks.
    localparam logic [7:0] SPCA_IO_STORE_MASK  = 8'h90;
    localparam logic [7:0] SPCA_IO_STORE_VAL   = 8'h90;
    localparam logic [7:0] SPCA_NIB_MASK       = 8'hF0;
    localparam logic [7:0] SPCA_CS_LOAD_VAL    = 8'h80;
    localparam logic [7:0] SPCA_CS_STORE_VAL   = 8'hC0;
    localparam logic [7:0] SPCA_KEY_CMD        = 8'hE0;

    // Control/status addresses.
    localparam logic [3:0] SPCA_ADDR_STATUS    = 4'h0;
    localparam logic [3:0] SPCA_ADDR_PHY_CTRL  = 4'h2;
    localparam logic [3:0] SPCA_ADDR_IDENT     = 4'hF;

    // Field positions and reset values.
    localparam int         SPCA_MEM_EN_BIT     = 1;
    localparam logic [2:0] SPCA_GUARD_RESET    = 3'h0;

    // Activation key and key length.
    localparam logic [63:0] SPCA_ACT_KEY       = 64'h1289AB45CDD888FF;
    localparam int          SPCA_KEY_BYTES     = 8;
    localparam logic [3:0]  SPCA_KEY_LAST      = 4'h7;

    // Idle bits on a receive to transmit turnaround: two always added, up to 128 guard bits.
    localparam logic [7:0]  SPCA_BASE_IDLE     = 8'h02;
    localparam logic [7:0]  SPCA_GUARD_MAX     = 8'h80;

    // Byte received from the physical layer.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } spca_byte_t;

    // Write request into the I/O space.
    typedef struct packed {
        logic       valid;
        logic [5:0] addr;
        logic [7:0] data;
    } spca_io_wr_t;

endpackage

//--- sim/spca_asserts.sv
// Port checker for the command decoder.
`timescale 1ns/10ps
module spca_asserts #(
    parameter logic [7:0] IDENT_CODE = 8'h5A
) (
    // Clock and reset.
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    // Decoder ports.
    input wire spca_pkg::spca_byte_t  rx_byte,
    input wire logic                  tx_load,
    input wire logic [7:0]            tx_data,
    input wire logic [7:0]            turn_idle_bits,
    input wire spca_pkg::spca_io_wr_t io_wr,
    input wire logic                  mem_prog_enabled
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_ld; tx_load |-> $past(rx_byte.valid) && $past(rx_byte.data[7:4]) == 4'h8; endproperty
    property p_io; io_wr.valid |-> $past(rx_byte.valid); endproperty
    property p_idle; turn_idle_bits inside {8'h82, 8'h42, 8'h22, 8'h12, 8'h0A, 8'h06, 8'h04, 8'h02};
    endproperty
    // A reset edge moves the outputs by itself, so the byte-driven checks skip it.
    property p_turn;
        $changed(turn_idle_bits) && $past(resetn) |-> $past(rx_byte.valid, 2);
    endproperty
    property p_en;
        $rose(mem_prog_enabled) |-> $past(rx_byte.valid) && $past(rx_byte.data) == 8'hFF;
    endproperty
    property p_clr;
        $fell(mem_prog_enabled) && $past(resetn)
            |-> $past(rx_byte.valid) && !$past(rx_byte.data[1]);
    endproperty
    property p_hold;
        !$past(rx_byte.valid) && $past(resetn) |-> $stable(mem_prog_enabled);
    endproperty
    property p_st;
        tx_load && $past(rx_byte.data) == 8'h80
            |-> tx_data == {6'h0, $past(mem_prog_enabled), 1'b0};
    endproperty
    property p_id; tx_load && $past(rx_byte.data) == 8'h8F |-> tx_data == IDENT_CODE; endproperty
    a_ld: assert property (p_ld) else $error("load without load opcode");
    a_io: assert property (p_io) else $error("io write without byte");
    a_idle: assert property (p_idle) else $error("bad idle count");
    a_turn: assert property (p_turn) else $error("idle count moved alone");
    a_en: assert property (p_en) else $error("enable without key");
    a_clr: assert property (p_clr) else $error("bad disable");
    a_hold: assert property (p_hold) else $error("enable moved alone");
    a_st: assert property (p_st) else $error("bad status read");
    a_id: assert property (p_id) else $error("bad ident read");
    c_en: cover property ($rose(mem_prog_enabled));
    c_clr: cover property ($fell(mem_prog_enabled));
    c_io: cover property (io_wr.valid);
endmodule
bind spca_top spca_asserts #(.IDENT_CODE(IDENT_CODE)) u_spca_asserts (.clk_sys(clk_sys),
    .resetn(resetn), .rx_byte(rx_byte), .tx_load(tx_load), .tx_data(tx_data),
    .turn_idle_bits(turn_idle_bits), .io_wr(io_wr), .mem_prog_enabled(mem_prog_enabled));

//--- sim/spca_prog_model.sv
// Programmer model that feeds bytes to the command decoder.
`timescale 1ns/10ps
module spca_prog_model (
    // Clock.
    input  wire logic           clk_sys,
    // Byte stream.
    output spca_pkg::spca_byte_t rx_byte
);
    initial rx_byte = '0;
    // After the strobe the data lines carry the inverted byte, never the old byte.
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_byte <= '{1'b1, b};
        @(posedge clk_sys);
        rx_byte <= '{1'b0, ~b};
    endtask
endmodule

//--- sim/spca_top_tb.sv
// Self-checking bench for the command decoder.
`timescale 1ns/10ps
module spca_top_tb;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary value.
    localparam logic [63:0] K = spca_pkg::SPCA_ACT_KEY;
    logic                  clk_sys = 1'b0;
    logic                  resetn = 1'b0;
    spca_pkg::spca_byte_t  rx_byte;
    logic                  tx_load;
    logic [7:0]            tx_data;
    logic [7:0]            turn_idle_bits;
    spca_pkg::spca_io_wr_t io_wr;
    logic                  mem_prog_enabled;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    logic [7:0]            idle_tab [8] = '{8'h82, 8'h42, 8'h22, 8'h12,
                                            8'h0A, 8'h06, 8'h04, 8'h02};
    always #4 clk_sys = ~clk_sys;
    spca_top #(.IDENT_CODE(ID)) u_spca_top (.clk_sys(clk_sys), .resetn(resetn),
        .rx_byte(rx_byte), .tx_load(tx_load), .tx_data(tx_data),
        .turn_idle_bits(turn_idle_bits), .io_wr(io_wr),
        .mem_prog_enabled(mem_prog_enabled));
    spca_prog_model u_spca_prog_model (.clk_sys(clk_sys), .rx_byte(rx_byte));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tx(input logic [7:0] b);
        u_spca_prog_model.send(b);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        tx({4'h8, a});
        #1;
        chk({7'h0, tx_load}, 8'h01);
        chk(tx_data, exp);
        @(posedge clk_sys);
        #1;
        chk({7'h0, tx_load}, 8'h00);
    endtask
    task automatic key(input logic [63:0] k);
        tx(8'hE0);
        for (int i = 7; i >= 0; i--) tx(k[i*8 +: 8]);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        chk({7'h0, mem_prog_enabled}, 8'h00);
        chk(turn_idle_bits, 8'h82);
        rd(4'h0, 8'h00);
        rd(4'hF, ID);
        for (int g = 0; g < 8; g++) begin
            tx(8'hC2);
            tx({5'h1F, g[2:0]});
            repeat (3) @(posedge clk_sys);
            chk(turn_idle_bits, idle_tab[g]);
            rd(4'h2, {5'h0, g[2:0]});
        end
        tx(8'hB5);
        tx(8'hA5);
        #1;
        chk({1'b0, io_wr.addr, io_wr.valid}, 8'h2B);
        chk(io_wr.data, 8'hA5);
        @(posedge clk_sys);
        #1;
        chk({7'h0, io_wr.valid}, 8'h00);
        key(K ^ 64'h1);
        chk({7'h0, mem_prog_enabled}, 8'h00);
        key(K);
        rd(4'h0, 8'h02);
        tx(8'hCF);
        tx(8'h00);
        rd(4'hF, ID);
        rd(4'h3, 8'h00);
        tx(8'hC0);
        tx(8'h00);
        repeat (2) @(posedge clk_sys);
        rd(4'h0, 8'h00);
        key(K);
        chk({7'h0, mem_prog_enabled}, 8'h01);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        chk(turn_idle_bits, 8'h82);
        chk({7'h0, mem_prog_enabled}, 8'h00);
        chk(tx_data, 8'h00);
        print_verdict;
    end
endmodule
